// ==== rtl/plr_pkg.sv ====
package plr_pkg;

	// ----------------------------------------------------------------
	// Fixed-point formats
	// ----------------------------------------------------------------
	localparam int          FRAC        = 4;
	localparam int          TFR         = 8;
	localparam logic [8:0]  T_ONE       = 9'h100;
	localparam logic [16:0] HALF_Q      = 17'h00008;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  REG_CTRL    = 4'h0;
	localparam logic [3:0]  REG_LWIDTH  = 4'h4;
	localparam logic [3:0]  REG_STATUS  = 4'h8;

	localparam int          CTRL_AA     = 0;
	localparam int          CTRL_SQ     = 1;
	localparam int          CTRL_MS     = 2;
	localparam int          CTRL_ORG    = 3;
	localparam int          CTRL_LAA    = 4;
	localparam int          CTRL_SUB    = 8;
	localparam int          CTRL_SBC    = 12;
	localparam int          ST_ERR      = 0;
	localparam int          ST_BUSY     = 1;

	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [15:0] LWIDTH_RST  = 16'h0100;
	localparam logic [1:0]  SBC_ONE     = 2'h1;

	// ----------------------------------------------------------------
	// Point widths and coverage
	// ----------------------------------------------------------------
	localparam logic [7:0]  AA_MIN      = 8'h02;
	localparam logic [7:0]  AA_MAX      = 8'h40;
	localparam logic [7:0]  AA_GRAD     = 8'h01;
	localparam logic [3:0]  ALIAS_MAX   = 4'h8;
	localparam logic [4:0]  COV_FULL    = 5'h10;
	localparam logic [3:0]  MASK_FULL   = 4'hf;
	localparam logic [15:0] SPR_HALF    = 16'h0080;
	localparam logic [15:0] SPR_ONE     = 16'h0100;
	localparam int          AA_OFF0     = 2;
	localparam int          AA_OFF_STEP = 4;
	localparam logic [15:0] MS_SX       = 16'ha2e6;
	localparam logic [15:0] MS_SY       = 16'hea62;

	// ----------------------------------------------------------------
	// Qualifiers and phases
	// ----------------------------------------------------------------
	localparam logic [1:0]  Q_PERSP     = 2'h0;
	localparam logic [1:0]  Q_NOPERSP   = 2'h1;
	localparam logic [1:0]  Q_FLAT      = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_POINT = 3'b010,
		ST_LINE  = 3'b100
	} plr_phase_t;

endpackage

// ==== rtl/plr_top.sv ====
// Summary of operation
// - Plain point fragments carry vertex data
// - Round AA point: square hits circle, area
// - AA widths include 1.0, nearest graded
// - Square mode: pixel centres inside square
// - Sprite coords out, substitute chosen sets
// - s = half plus offset over size
// - t sign follows sprite origin
// - Substituted r and q are 0, 1
// - Sprite widths superset, nearest supported
// - Multisample: sample hits, AA ignored
// - Coverage bit set per inside sample
// - Multisample data unchanged except sprite coords
// - Line width resets 1.0, rejects nonpositive
// - Slope within [-1,1] means x-major
// - Diamond-exit rule, end diamond excluded
// - Half-open: end fragment never drawn
// - Approximation within one unit, count
// - One fragment per major column/row
// - Joined segments: no duplicate, no gap
// - Perspective-correct data using clip w
// - Depth interpolated linearly in t
// - noperspective linear, flat from provoking
// - Square and round modes off after reset
`timescale 1ns/1ps
`default_nettype none
module plr_top
	import plr_pkg::*;
#(
	parameter int NATTR    = 8,
	parameter int AW       = 16,
	parameter int TEX_SETS = 2
) (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  arst_n,
	// Register port
	input  wire logic [3:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	output logic                       bad_argument_error,
	// Primitive input
	input  wire logic                  prim_valid,
	output logic                       prim_ready,
	input  wire logic                  prim_line,
	input  wire logic [15:0]           va_x,
	input  wire logic [15:0]           va_y,
	input  wire logic [15:0]           vb_x,
	input  wire logic [15:0]           vb_y,
	input  wire logic [AW-1:0]         va_z,
	input  wire logic [AW-1:0]         vb_z,
	input  wire logic [15:0]           va_w,
	input  wire logic [15:0]           vb_w,
	input  wire logic [NATTR*AW-1:0]   va_attr,
	input  wire logic [NATTR*AW-1:0]   vb_attr,
	input  wire logic [2*NATTR-1:0]    attr_qual,
	input  wire logic [7:0]            point_size,
	// Fragment output
	output logic                       frag_valid,
	input  wire logic                  frag_ready,
	output logic      [11:0]           frag_x,
	output logic      [11:0]           frag_y,
	output logic      [4:0]            frag_cov_area,
	output logic      [3:0]            frag_cov_mask,
	output logic      [AW-1:0]         frag_depth,
	output logic      [NATTR*AW-1:0]   frag_attr,
	output logic      [31:0]           sprite_coord_output
);

	typedef struct packed {
		plr_phase_t                st;
		logic                      rdy;
		logic                      booted;
		logic [31:0]               ctrl;
		logic [15:0]               lwidth;
		logic                      err;
		logic [15:0]               fcount;
		logic [31:0]               rdata;
		logic                      aa;
		logic                      sq;
		logic                      ms;
		logic                      org_bot;
		logic [TEX_SETS-1:0]       sub;
		logic [15:0]               ax;
		logic [15:0]               ay;
		logic [15:0]               bx;
		logic [15:0]               by;
		logic [AW-1:0]             az;
		logic [AW-1:0]             bz;
		logic [15:0]               aw;
		logic [15:0]               bw;
		logic [NATTR*AW-1:0]       aattr;
		logic [NATTR*AW-1:0]       battr;
		logic [2*NATTR-1:0]        qual;
		logic [7:0]                sz;
		logic signed [17:0]        cx;
		logic signed [17:0]        cy;
		logic signed [13:0]        x;
		logic signed [13:0]        y;
		logic signed [13:0]        x0;
		logic signed [13:0]        x1;
		logic signed [13:0]        y1;
		logic                      xmaj;
		logic                      down;
		logic [12:0]               nleft;
		logic                      ov;
		logic                      opoint;
		logic                      oaa;
		logic                      oms;
		logic                      osprite;
		logic [11:0]               ox;
		logic [11:0]               oy;
		logic [4:0]                oarea;
		logic [3:0]                omask;
		logic [AW-1:0]             oz;
		logic [NATTR*AW-1:0]       oattr;
		logic [15:0]               os;
		logic [15:0]               ot;
	} plr_state_t;

	plr_state_t            s_reg;
	plr_state_t            s_next;

	logic                  can_emit;
	logic                  adv_line;
	logic                  pt_hit;
	logic [4:0]            pt_area;
	logic [3:0]            pt_mask;
	logic signed [17:0]    px;
	logic signed [17:0]    py;
	logic [15:0]           spr_s;
	logic [15:0]           spr_t;
	logic [NATTR*AW-1:0]   pt_attr;
	logic                  su_ms;
	logic                  su_sq;
	logic [4:0]            su_wi;
	logic [16:0]           su_rx;
	logic [16:0]           su_ry;
	logic [7:0]            su_sz;
	logic signed [17:0]    su_cx;
	logic signed [17:0]    su_cy;
	logic signed [17:0]    su_hs;
	logic [15:0]           su_adx;
	logic [15:0]           su_ady;
	logic                  su_xmaj;
	logic [11:0]           su_pa;
	logic [11:0]           su_pb;
	logic signed [17:0]    l_amaj;
	logic signed [17:0]    l_bmaj;
	logic signed [17:0]    l_amin;
	logic signed [17:0]    l_bmin;
	logic signed [17:0]    ln_mc;
	logic signed [17:0]    ln_dmaj;
	logic signed [35:0]    ln_prod;
	logic signed [17:0]    ln_mq;
	logic signed [17:0]    ln_fx;
	logic signed [17:0]    ln_fy;
	logic signed [47:0]    ln_num;
	logic signed [47:0]    ln_den;
	logic signed [47:0]    ln_tq;
	logic [8:0]            ln_t;
	logic [AW-1:0]         ln_z;
	logic [NATTR*AW-1:0]   ln_attr;

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] fit_width(input logic [7:0] sz);
		logic [8:0] r;
		r = ((9'(sz) + 9'(AA_GRAD >> 1)) / 9'(AA_GRAD)) * 9'(AA_GRAD);
		if (r < 9'(AA_MIN)) begin
			r = 9'(AA_MIN);
		end else if (r > 9'(AA_MAX)) begin
			r = 9'(AA_MAX);
		end
		fit_width = r[7:0];
	endfunction

	function automatic logic in_region(input logic signed [17:0] dx,
			input logic signed [17:0] dy, input logic [7:0] sz, input logic circ);
		logic signed [37:0] d2;
		logic signed [37:0] r2;
		logic signed [18:0] ex;
		logic signed [18:0] ey;
		d2 = 38'(dx) * 38'(dx) + 38'(dy) * 38'(dy);
		r2 = 38'(sz);
		r2 = r2 * r2;
		ex = (dx < 0) ? -19'(dx) : 19'(dx);
		ey = (dy < 0) ? -19'(dy) : 19'(dy);
		if (circ) begin
			in_region = (d2 <<< 2) < r2;
		end else begin
			in_region = ((ex <<< 1) < 19'(sz)) && ((ey <<< 1) < 19'(sz));
		end
	endfunction

	function automatic logic [15:0] sprite_coord(input logic signed [17:0] d,
			input logic [7:0] sz, input logic neg);
		logic signed [27:0] q;
		q = (28'(d) <<< 8) / signed'(28'(sz));
		if (neg) begin
			q = -q;
		end
		q = q + signed'(28'(SPR_HALF));
		if (q < 0) begin
			q = '0;
		end else if (q > signed'(28'(SPR_ONE))) begin
			q = 28'(SPR_ONE);
		end
		sprite_coord = q[15:0];
	endfunction

	function automatic logic [AW-1:0] interp(input logic [AW-1:0] fa,
			input logic [AW-1:0] fb, input logic [8:0] t, input logic [15:0] wa,
			input logic [15:0] wb, input logic [1:0] q);
		logic [63:0] num;
		logic [63:0] den;
		logic [8:0]  u;
		u = T_ONE - t;
		num = 64'(u) * 64'(fa) * 64'(wb) + 64'(t) * 64'(fb) * 64'(wa);
		den = 64'(u) * 64'(wb) + 64'(t) * 64'(wa);
		if (q == Q_FLAT) begin
			interp = fb;
		end else if (q == Q_NOPERSP) begin
			interp = AW'((64'(u) * 64'(fa) + 64'(t) * 64'(fb)) >> TFR);
		end else if (den == 64'h0) begin
			interp = fa;
		end else begin
			interp = AW'(num / den);
		end
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.booted = 1'b1;
		s_next.rdata = '0;

		if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL:   s_next.ctrl = reg_wdata;
				REG_LWIDTH: begin
					if (reg_wdata[15] || reg_wdata[15:0] == 16'h0) begin
						s_next.err = 1'b1;
					end else begin
						s_next.lwidth = reg_wdata[15:0];
					end
				end
				REG_STATUS: begin
					if (reg_wdata[ST_ERR]) begin
						s_next.err = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL:   s_next.rdata = s_reg.ctrl;
				REG_LWIDTH: s_next.rdata = {16'h0, s_reg.lwidth};
				REG_STATUS: s_next.rdata = {s_reg.fcount, 14'h0,
					s_reg.st != ST_IDLE || s_reg.ov, s_reg.err};
				default:    s_next.rdata = '0;
			endcase
		end

		can_emit = !s_reg.ov || frag_ready;
		if (s_reg.ov && frag_ready) begin
			s_next.ov = 1'b0;
			s_next.fcount = s_reg.fcount + 16'h1;
		end

		px = {s_reg.x, 4'h8};
		py = {s_reg.y, 4'h8};
		pt_area = '0;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 4; j++) begin
				if (in_region({s_reg.x, 4'h0} + 18'(AA_OFF0 + AA_OFF_STEP * i) - s_reg.cx,
						{s_reg.y, 4'h0} + 18'(AA_OFF0 + AA_OFF_STEP * j) - s_reg.cy,
						s_reg.sz, 1'b1)) begin
					pt_area = pt_area + 5'h1;
				end
			end
		end
		for (int k = 0; k < 4; k++) begin
			pt_mask[k] = in_region({s_reg.x, 4'h0} + 18'(MS_SX[4*k +: 4]) - s_reg.cx,
				{s_reg.y, 4'h0} + 18'(MS_SY[4*k +: 4]) - s_reg.cy, s_reg.sz, !s_reg.sq);
		end
		if (s_reg.ms) begin
			pt_hit = |pt_mask;
		end else if (s_reg.aa) begin
			pt_hit = pt_area != 5'h0;
		end else begin
			pt_hit = in_region(px - s_reg.cx, py - s_reg.cy, s_reg.sz, 1'b0);
		end
		pt_hit = pt_hit && !s_reg.x[13] && !s_reg.y[13];
		spr_s = sprite_coord(px - s_reg.cx, s_reg.sz, 1'b0);
		spr_t = sprite_coord(py - s_reg.cy, s_reg.sz, !s_reg.org_bot);
		pt_attr = s_reg.aattr;
		for (int k = 0; k < TEX_SETS; k++) begin
			if (s_reg.sq && s_reg.sub[k]) begin
				pt_attr[(4*k)*AW +: AW]   = AW'(spr_s);
				pt_attr[(4*k+1)*AW +: AW] = AW'(spr_t);
				pt_attr[(4*k+2)*AW +: AW] = '0;
				pt_attr[(4*k+3)*AW +: AW] = AW'(SPR_ONE);
			end
		end

		su_ms = s_reg.ctrl[CTRL_MS] && s_reg.ctrl[CTRL_SBC +: 2] == SBC_ONE;
		su_sq = s_reg.ctrl[CTRL_SQ];
		su_wi = 5'((17'(point_size) + HALF_Q) >> FRAC);
		if (su_wi == 5'h0) begin
			su_wi = 5'h1;
		end else if (su_wi > 5'(ALIAS_MAX)) begin
			su_wi = 5'(ALIAS_MAX);
		end
		su_rx = {1'b0, va_x} + HALF_Q;
		su_ry = {1'b0, va_y} + HALF_Q;
		if (su_sq || su_ms || s_reg.ctrl[CTRL_AA]) begin
			su_sz = fit_width(point_size);
			su_cx = {2'b0, va_x};
			su_cy = {2'b0, va_y};
		end else if (su_wi[0]) begin
			su_sz = {su_wi[3:0], 4'h0};
			su_cx = {2'b0, va_x[15:4], 4'h8};
			su_cy = {2'b0, va_y[15:4], 4'h8};
		end else begin
			su_sz = {su_wi[3:0], 4'h0};
			su_cx = {1'b0, su_rx[16:4], 4'h0};
			su_cy = {1'b0, su_ry[16:4], 4'h0};
		end
		su_hs = {11'h0, su_sz[7:1]};
		su_adx = (vb_x >= va_x) ? vb_x - va_x : va_x - vb_x;
		su_ady = (vb_y >= va_y) ? vb_y - va_y : va_y - vb_y;
		su_xmaj = su_ady <= su_adx;
		su_pa = su_xmaj ? va_x[15:4] : va_y[15:4];
		su_pb = su_xmaj ? vb_x[15:4] : vb_y[15:4];

		l_amaj = {2'b0, s_reg.xmaj ? s_reg.ax : s_reg.ay};
		l_bmaj = {2'b0, s_reg.xmaj ? s_reg.bx : s_reg.by};
		l_amin = {2'b0, s_reg.xmaj ? s_reg.ay : s_reg.ax};
		l_bmin = {2'b0, s_reg.xmaj ? s_reg.by : s_reg.bx};
		ln_mc = {s_reg.x, 4'h8};
		ln_dmaj = (l_bmaj == l_amaj) ? 18'sd1 : l_bmaj - l_amaj;
		ln_prod = 36'(ln_mc - l_amaj) * 36'(l_bmin - l_amin);
		ln_mq = l_amin + 18'(ln_prod / 36'(ln_dmaj));
		ln_fx = s_reg.xmaj ? ln_mc : {ln_mq[17:4], 4'h8};
		ln_fy = s_reg.xmaj ? {ln_mq[17:4], 4'h8} : ln_mc;
		ln_num = 48'(ln_fx - signed'({2'b0, s_reg.ax})) * 48'(signed'({2'b0, s_reg.bx})
			- signed'({2'b0, s_reg.ax})) + 48'(ln_fy - signed'({2'b0, s_reg.ay}))
			* 48'(signed'({2'b0, s_reg.by}) - signed'({2'b0, s_reg.ay}));
		ln_den = 48'(l_bmaj - l_amaj) * 48'(l_bmaj - l_amaj)
			+ 48'(l_bmin - l_amin) * 48'(l_bmin - l_amin);
		ln_tq = (ln_den == 48'sd0) ? 48'sd0 : (ln_num <<< TFR) / ln_den;
		if (ln_tq < 0) begin
			ln_t = '0;
		end else if (ln_tq > 48'(T_ONE)) begin
			ln_t = T_ONE;
		end else begin
			ln_t = ln_tq[8:0];
		end
		ln_z = interp(s_reg.az, s_reg.bz, ln_t, s_reg.aw, s_reg.bw, Q_NOPERSP);
		for (int i = 0; i < NATTR; i++) begin
			ln_attr[i*AW +: AW] = interp(s_reg.aattr[i*AW +: AW], s_reg.battr[i*AW +: AW],
				ln_t, s_reg.aw, s_reg.bw, s_reg.qual[2*i +: 2]);
		end
		adv_line = s_reg.st == ST_LINE && can_emit;

		unique case (s_reg.st)
			ST_IDLE: begin
				if (prim_valid) begin
					{s_next.ax, s_next.ay, s_next.bx, s_next.by} = {va_x, va_y, vb_x, vb_y};
					{s_next.az, s_next.bz, s_next.aw, s_next.bw} = {va_z, vb_z, va_w, vb_w};
					{s_next.aattr, s_next.battr, s_next.qual} = {va_attr, vb_attr, attr_qual};
					s_next.sub = s_reg.ctrl[CTRL_SUB +: TEX_SETS];
					s_next.org_bot = s_reg.ctrl[CTRL_ORG];
					s_next.ms = su_ms;
					s_next.sq = su_sq;
					s_next.aa = s_reg.ctrl[CTRL_AA] && !su_sq && !su_ms;
					s_next.sz = su_sz;
					s_next.cx = su_cx;
					s_next.cy = su_cy;
					s_next.xmaj = su_xmaj;
					if (!prim_line) begin
						s_next.x0 = 14'((su_cx - su_hs - 18'sd16) >>> FRAC);
						s_next.x = 14'((su_cx - su_hs - 18'sd16) >>> FRAC);
						s_next.y = 14'((su_cy - su_hs - 18'sd16) >>> FRAC);
						s_next.x1 = 14'((su_cx + su_hs + 18'sd16) >>> FRAC);
						s_next.y1 = 14'((su_cy + su_hs + 18'sd16) >>> FRAC);
						s_next.st = ST_POINT;
					end else begin
						s_next.x = {2'b0, su_pa};
						s_next.x1 = {2'b0, su_pb};
						s_next.down = su_pb < su_pa;
						s_next.nleft = (su_pb < su_pa) ? 13'(su_pa - su_pb) : 13'(su_pb - su_pa);
						if (su_pa != su_pb) begin
							s_next.st = ST_LINE;
						end
					end
				end
			end
			ST_POINT: begin
				if (can_emit) begin
					// vertex data on point fragments except substituted sprite sets
					if (pt_hit) begin
						s_next.ov = 1'b1;
						s_next.ox = s_reg.x[11:0];
						s_next.oy = s_reg.y[11:0];
						s_next.oarea = s_reg.aa ? pt_area : COV_FULL;
						s_next.omask = s_reg.ms ? pt_mask : MASK_FULL;
						s_next.oz = s_reg.az;
						s_next.oattr = pt_attr;
						s_next.os = s_reg.sq ? spr_s : 16'h0;
						s_next.ot = s_reg.sq ? spr_t : 16'h0;
						{s_next.opoint, s_next.oaa} = {1'b1, s_reg.aa};
						{s_next.oms, s_next.osprite} = {s_reg.ms, s_reg.sq};
					end
					if (s_reg.x == s_reg.x1) begin
						s_next.x = s_reg.x0;
						if (s_reg.y == s_reg.y1) begin
							s_next.st = ST_IDLE;
						end else begin
							s_next.y = s_reg.y + 14'sd1;
						end
					end else begin
						s_next.x = s_reg.x + 14'sd1;
					end
				end
			end
			ST_LINE: begin
				if (adv_line) begin
					s_next.ov = 1'b1;
					s_next.ox = ln_fx[15:4];
					s_next.oy = ln_fy[15:4];
					s_next.oarea = COV_FULL;
					s_next.omask = MASK_FULL;
					s_next.oz = ln_z;
					s_next.oattr = ln_attr;
					{s_next.os, s_next.ot} = 32'h0;
					{s_next.opoint, s_next.oaa, s_next.oms, s_next.osprite} = 4'h0;
					s_next.x = s_reg.down ? s_reg.x - 14'sd1 : s_reg.x + 14'sd1;
					s_next.nleft = s_reg.nleft - 13'h1;
					if (s_reg.nleft == 13'h1) begin
						s_next.st = ST_IDLE;
					end
				end
			end
		endcase
		s_next.rdy = s_next.st == ST_IDLE;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.rdy <= 1'b1;
			s_reg.ctrl <= CTRL_RST;
			s_reg.lwidth <= LWIDTH_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata;
	assign bad_argument_error = s_reg.err;
	assign prim_ready = s_reg.rdy;
	assign frag_valid = s_reg.ov;
	assign frag_x = s_reg.ox;
	assign frag_y = s_reg.oy;
	assign frag_cov_area = s_reg.oarea;
	assign frag_cov_mask = s_reg.omask;
	assign frag_depth = s_reg.oz;
	assign frag_attr = s_reg.oattr;
	assign sprite_coord_output = {s_reg.ot, s_reg.os};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_out_hold: assert property (
		frag_valid && !frag_ready |=> frag_valid && $stable(frag_x) && $stable(frag_y)
			&& $stable(frag_attr)) else $error("fragment changed while stalled");
	a_accept_idle: assert property (
		prim_valid && prim_ready && (!prim_line || su_pa != su_pb) |=> !prim_ready)
		else $error("primitive accepted without leaving idle");
	a_bad_width: assert property (
		reg_wr && reg_addr == REG_LWIDTH && (reg_wdata[15] || reg_wdata[15:0] == 16'h0)
		|=> $stable(s_reg.lwidth) && bad_argument_error) else $error("bad width accepted");
	a_reset_modes: assert property (
		!s_reg.booted |-> !s_reg.ctrl[CTRL_AA] && !s_reg.ctrl[CTRL_SQ]
			&& s_reg.lwidth == LWIDTH_RST) else $error("mode or width wrong after reset");
	a_point_data: assert property (
		frag_valid && s_reg.opoint && !s_reg.osprite && s_reg.st == ST_POINT
		|-> frag_attr == s_reg.aattr) else $error("point data not from vertex");
	a_sprite_rq: assert property (
		frag_valid && s_reg.osprite && s_reg.sub[0] && s_reg.st == ST_POINT
		|-> frag_attr[2*AW +: AW] == '0 && frag_attr[3*AW +: AW] == AW'(SPR_ONE))
		else $error("substituted r or q wrong");
	a_ms_cover: assert property (
		frag_valid && s_reg.oms |-> frag_cov_mask != 4'h0 && frag_cov_area == COV_FULL)
		else $error("multisample fragment without sample");
	a_aa_area: assert property (
		frag_valid && s_reg.oaa |-> frag_cov_area inside {[5'h1:COV_FULL]}
			&& frag_cov_mask == MASK_FULL) else $error("antialiased coverage out of range");
	a_major_step: assert property (
		adv_line && s_reg.nleft > 13'h1 |=> (s_reg.x - $past(s_reg.x) == 14'sd1)
			|| ($past(s_reg.x) - s_reg.x == 14'sd1)) else $error("major index not unit step");
	a_half_open: assert property (
		s_reg.st == ST_LINE |-> s_reg.x != s_reg.x1) else $error("end fragment reached");

	c_sprite: cover property (frag_valid && frag_ready && s_reg.osprite);
	c_msample: cover property (frag_valid && frag_ready && s_reg.oms);
	c_line: cover property (frag_valid && frag_ready && !s_reg.opoint);
	c_stall: cover property (frag_valid && !frag_ready [*3]);

endmodule
`default_nettype wire

// ==== dv/plr_frag_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module plr_frag_sink (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Fragment stream
	input  wire logic        frag_valid,
	output logic             frag_ready,
	input  wire logic [11:0] frag_x,
	input  wire logic [11:0] frag_y,
	input  wire logic [15:0] frag_depth,
	input  wire logic [63:0] frag_attr,
	input  wire logic [4:0]  frag_cov_area,
	input  wire logic [3:0]  frag_cov_mask,
	input  wire logic [31:0] sprite_coord_output
);
	logic [1:0]   stall_reg;
	int           n;
	logic [103:0] got [8];
	logic [40:0]  side_reg;
	assign frag_ready = (stall_reg != 2'h0);
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stall_reg <= 2'h0;
			n <= 0;
			side_reg <= '0;
		end else begin
			stall_reg <= (stall_reg == 2'h2) ? 2'h0 : stall_reg + 2'h1;
			if (frag_valid && frag_ready) begin
				got[n[2:0]] <= {frag_x, frag_y, frag_depth, frag_attr};
				n <= n + 1;
				side_reg <= {frag_cov_area, frag_cov_mask, sprite_coord_output};
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/point_line_rasterizer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module point_line_rasterizer_test
	import plr_pkg::*;
;
	logic         mclk, arst_n, reg_wr, reg_rd, prim_valid, prim_ready, prim_line;
	logic         bad_argument_error, frag_valid, frag_ready;
	logic [3:0]   reg_addr, frag_cov_mask;
	logic [31:0]  reg_wdata, reg_rdata, sprite_coord_output, d;
	logic [15:0]  va_x, va_y, vb_x, vb_y, va_z, vb_z, va_w, vb_w, frag_depth;
	logic [127:0] va_attr, vb_attr, frag_attr;
	logic [15:0]  attr_qual;
	logic [7:0]   point_size;
	logic [11:0]  frag_x, frag_y;
	logic [4:0]   frag_cov_area;
	int           mismatches, check_count, cyc, base;

	plr_top uut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bad_argument_error(bad_argument_error), .prim_valid(prim_valid),
		.prim_ready(prim_ready), .prim_line(prim_line), .va_x(va_x), .va_y(va_y),
		.vb_x(vb_x), .vb_y(vb_y), .va_z(va_z), .vb_z(vb_z), .va_w(va_w), .vb_w(vb_w),
		.va_attr(va_attr), .vb_attr(vb_attr), .attr_qual(attr_qual),
		.point_size(point_size), .frag_valid(frag_valid), .frag_ready(frag_ready),
		.frag_x(frag_x), .frag_y(frag_y), .frag_cov_area(frag_cov_area),
		.frag_cov_mask(frag_cov_mask), .frag_depth(frag_depth), .frag_attr(frag_attr),
		.sprite_coord_output(sprite_coord_output));
	plr_frag_sink sink (.mclk(mclk), .arst_n(arst_n), .frag_valid(frag_valid),
		.frag_ready(frag_ready), .frag_x(frag_x), .frag_y(frag_y),
		.frag_depth(frag_depth), .frag_attr(frag_attr[63:0]),
		.frag_cov_area(frag_cov_area), .frag_cov_mask(frag_cov_mask),
		.sprite_coord_output(sprite_coord_output));

	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic send(input logic ln, input logic [15:0] ax, ay, bx, by);
		logic ok;
		@(posedge mclk);
		base = sink.n;
		{prim_line, va_x, va_y, vb_x, vb_y} <= {ln, ax, ay, bx, by};
		prim_valid <= 1'b1;
		do begin
			@(negedge mclk);
			ok = prim_ready;
			@(posedge mclk);
		end while (ok !== 1'b1);
		prim_valid <= 1'b0;
		repeat (300) begin
			@(negedge mclk);
			if (prim_ready === 1'b1 && frag_valid === 1'b0) break;
		end
		repeat (2) @(negedge mclk);
	endtask

	task automatic t_regs();
		rd(REG_CTRL);
		`CHK(d, CTRL_RST)
		wr(REG_LWIDTH, 32'h0);
		rd(REG_LWIDTH);
		`CHK(d[15:0], LWIDTH_RST)
		rd(REG_STATUS);
		`CHK(d[ST_ERR], 1'b1)
		`CHK(bad_argument_error, 1'b1)
		wr(REG_LWIDTH, 32'h8000);
		rd(REG_LWIDTH);
		`CHK(d[15:0], LWIDTH_RST)
		wr(REG_LWIDTH, 32'h0200);
		rd(REG_LWIDTH);
		`CHK(d[15:0], 16'h0200)
		wr(REG_STATUS, 32'h1);
		@(negedge mclk);
		`CHK(bad_argument_error, 1'b0)
		rd(4'hc);
		`CHK(d, 32'h0)
	endtask

	task automatic t_point(input logic [31:0] ctrl, input logic [15:0] v,
			input logic [63:0] want, input logic [40:0] side);
		wr(REG_CTRL, ctrl);
		send(1'b0, v, v, 16'h0, 16'h0);
		`CHK(sink.n - base, 1)
		`CHK(sink.got[base[2:0]], {12'h5, 12'h5, va_z, want})
		`CHK(sink.side_reg, side)
	endtask

	task automatic t_line();
		wr(REG_CTRL, 32'h0);
		send(1'b1, 16'h0008, 16'h0008, 16'h0038, 16'h0008);
		`CHK(sink.n - base, 3)
		for (int i = 0; i < 3; i++) begin
			`CHK(sink.got[(base + i) % 8][103:80], {i[11:0], 12'h0})
		end
		`CHK(sink.got[base[2:0]][79:64], va_z)
		`CHK(sink.got[base[2:0]][15:0], vb_attr[15:0])
		`CHK(sink.got[base[2:0]][31:16], va_attr[15:0])
	endtask

	initial begin
		{mclk, arst_n, reg_wr, reg_rd, prim_valid, prim_line} = 6'h0;
		{reg_addr, reg_wdata, va_x, va_y, vb_x, vb_y} = '0;
		{va_z, vb_z, va_w, vb_w} = {16'h0200, 16'h0600, 16'h0100, 16'h0100};
		va_attr = {8{16'h1234}};
		vb_attr = {8{16'h5678}};
		attr_qual = 16'h0002;
		point_size = 8'h10;
		{mismatches, check_count, cyc} = '0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		t_regs();
		t_point(32'h0, 16'h0058, va_attr[63:0], 41'h10f_0000_0000);
		// Twelve of sixteen subsamples inside
		t_point(32'h1, 16'h0058, va_attr[63:0], 41'h0cf_0000_0000);
		// Multisample with round mode set
		t_point(32'h1005, 16'h0058, va_attr[63:0], 41'h10f_0000_0000);
		// Sprite set 0 substituted, origin top then bottom
		t_point(32'h102, 16'h0054, 64'h0100_0000_0040_00c0, 41'h10f_0040_00c0);
		t_point(32'h10a, 16'h0054, 64'h0100_0000_00c0_00c0, 41'h10f_00c0_00c0);
		t_line();
		rd(REG_STATUS);
		`CHK(d[31:16], 16'(sink.n))
		`CHK(d[1], 1'b0)
		complete_run();
	end
endmodule
`default_nettype wire
